// file: pkg/host_port_pkg.sv
/*
  host_port_pkg: register offsets, field positions, reset values and counts
  for the host port, timer and interrupt block.
  assumes the host bus is 8 bits wide with a 256-byte address space.
*/
package host_port_pkg;

    // directly addressed registers
    localparam logic [7:0] OFF_RUN_CTRL = 8'h00;
    localparam logic [7:0] OFF_IEN_LO = 8'h02;
    localparam logic [7:0] OFF_IEN_HI = 8'h03;
    localparam logic [7:0] OFF_TIMER_CAUSE = 8'h04;
    localparam logic [7:0] OFF_ALARM_CAUSE = 8'h05;
    localparam logic [7:0] OFF_SPAD_RSEL = 8'h08;
    localparam logic [7:0] OFF_SPAD_WSEL = 8'h09;
    localparam logic [7:0] OFF_METER_LO = 8'h0a;
    localparam logic [7:0] OFF_METER_HI = 8'h0b;
    localparam logic [7:0] OFF_RELOAD_TRIG = 8'h0c;
    localparam logic [7:0] OFF_RUN_ENABLE = 8'h0d;
    localparam logic [7:0] OFF_AUTO_RELOAD = 8'h0e;
    localparam logic [7:0] OFF_INTERVAL_BASE = 8'h10;
    localparam logic [7:0] OFF_INTERVAL_LAST = 8'h1f;
    localparam logic [7:0] OFF_WINDOW_BASE = 8'h7c;

    // field position and block sizes
    localparam int RUN_MODE_BIT = 0;
    localparam int NUM_TIMERS = 8;
    localparam int NUM_STARTUP = 4;
    localparam int NUM_ALARMS = 4;
    localparam int WINDOW_BYTES = 4;
    localparam int SPAD_BYTES = 64;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;

    // counts
    localparam int PRESCALE_DIV = 1024;
    localparam int SYNC_STAGES = 3;

    // pin group sampled through the synchroniser
    typedef struct packed {
        logic cs_n;
        logic rd_ds_n;
        logic wr_rw;
        logic ale;
        logic style;
        logic mux;
        logic sym;
        logic [NUM_ALARMS-1:0] alarm;
        logic [7:0] ad;
        logic [7:0] addr;
    } host_pins_t;

    // idle pin levels; filter resets here so no false edge follows reset
    localparam host_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_ds_n: 1'b1, wr_rw: 1'b1, ale: 1'b0,
        style: 1'b0, mux: 1'b0, sym: 1'b0, alarm: '0, ad: 8'h00, addr: 8'h00};

    // captured host write
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } host_write_t;

endpackage

// file: rtl/host_port_timers_irq.sv
/*
  host_port_timers_irq: host bus slave, indirect scratch pad access, eight
  down counters with prescaler, twelve-source interrupt unit with masks.
  assumes every pin is asynchronous to clk and that the symbol clock and the
  host strobes are much slower than clk, so the three-stage filter sees them.
*/
// Operation
// R01 - indirect RAMs share one four-byte data window at 0x7c-0x7f; code also decodes 0x80-0xff as that window
// R02 - each RAM has read-select and write-select registers launching access
// R03 - read-select write puts location bytes in window; host waits two symbols
// R04 - host loads window then write-select; window contents are kept
// R05 - RAM access runs on symbol clock; host spaces accesses two symbols apart
// R06 - multiplexed mode captures address from shared bus at address-latch fall
// R07 - read drives bus while select and read strobe low; ends at either rise
// R08 - write taken while select and write strobe low; direction line brackets
// R09 - separate-bus mode takes address from dedicated address bus
// R10 - twelve sources combine onto one request output
// R11 - mask register bits enable each source onto the request
// R12 - timer causes and alarm causes reported in two cause registers
// R13 - timer status sets only on counter transition to zero
// R14 - alarm status cannot be cleared while its alarm is present
// R15 - request pin only pulls low or floats, open drain
// R16 - reset clears run-mode bit 0 of run control register
// R17 - eight down counters loaded from two-byte interval registers
// R18 - one written to restart bit reloads that timer
// R19 - enable bit lets timer count; continuous bit reloads after time-out
// R20 - four start-up timers share divide-by-1024 prescaler
// R21 - other four timers decrement once per symbol
// R22 - 64-byte scratch pad reachable through indirect access
// R23 - style pin high selects direction line and data strobe
// R24 - multiplex pin high puts address and data on shared pins
// R25 - reading meter low byte latches meter high byte
// R26 - disabled timer holds its count and raises no time-out
`timescale 1ns/10ps
module host_port_timers_irq
    import host_port_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // host bus strobes and mode straps
    input wire logic cs_n,
    input wire logic rd_ds_n,
    input wire logic wr_rw,
    input wire logic ale,
    input wire logic bus_style_sel,
    input wire logic mux_bus_sel,
    // host address and data
    input wire logic [7:0] addr,
    input wire logic [7:0] ad_i,
    output logic [7:0] ad_o,
    output logic ad_oe,
    // interrupt request, open drain
    output logic irq_n_o,
    output logic irq_n_oe,
    // line side status
    input wire logic symbol_clock,
    input wire logic [NUM_ALARMS-1:0] alarm_level,
    input wire logic [15:0] meter_value,
    output logic run_mode
);

    // refuse prescaler values the counter width cannot serve
    if (PRESCALE < 2 || PRESCALE > 65536) begin : g_bad_prescale
        $error("PRESCALE out of range");
    end

    localparam int PW = (PRESCALE > 2) ? $clog2(PRESCALE) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

    // offset decode shared by read and write paths
    function automatic logic is_interval(input logic [7:0] a);
        return (a >= OFF_INTERVAL_BASE) && (a <= OFF_INTERVAL_LAST);
    endfunction

    function automatic logic is_window(input logic [7:0] a);
        return a >= OFF_WINDOW_BASE;
    endfunction

    // three-stage pin filter; stage one only feeds stage two
    host_pins_t raw;
    host_pins_t s1_q, s2_q, s3_q, f_q;
    assign raw = '{cs_n: cs_n, rd_ds_n: rd_ds_n, wr_rw: wr_rw, ale: ale,
                   style: bus_style_sel, mux: mux_bus_sel, sym: symbol_clock,
                   alarm: alarm_level, ad: ad_i, addr: addr};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= PINS_IDLE;
            s2_q <= PINS_IDLE;
            s3_q <= PINS_IDLE;
            f_q <= PINS_IDLE;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a bit moves only when the last two stages agree
            f_q <= (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
        end
    end

    // strobe decode for both bus styles
    logic rd_act, wr_act, act;
    logic act_q, ale_q, sym_q;
    logic [7:0] ale_addr_q, cur_addr;
    host_write_t wcap_q;
    logic rd_start, sym_tick;

    always_comb begin
        // R23 strobe style select
        if (f_q.style) begin
            rd_act = !f_q.cs_n && !f_q.rd_ds_n && f_q.wr_rw;
            wr_act = !f_q.cs_n && !f_q.rd_ds_n && !f_q.wr_rw;
        end else begin
            rd_act = !f_q.cs_n && !f_q.rd_ds_n;
            wr_act = !f_q.cs_n && !f_q.wr_rw;
        end
        act = rd_act || wr_act;
    end

    // R24 address source select
    assign cur_addr = f_q.mux ? ale_addr_q : f_q.addr;
    assign rd_start = rd_act && !act_q;
    assign sym_tick = f_q.sym && !sym_q;

    // edge history of strobes and symbol clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            act_q <= 1'b0;
            ale_q <= 1'b0;
            sym_q <= 1'b0;
        end else begin
            act_q <= act;
            ale_q <= f_q.ale;
            sym_q <= f_q.sym;
        end
    end

    // R06 address latched at address-latch fall
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ale_addr_q <= RST_BYTE;
        end else if (ale_q && !f_q.ale) begin
            ale_addr_q <= f_q.ad;
        end
    end

    // R08 write captured while strobes low
    // R09 separate bus supplies address via cur_addr
    logic wr_seen_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wcap_q <= '0;
            wr_seen_q <= 1'b0;
        end else begin
            if (wr_act) begin
                wcap_q <= '{addr: cur_addr, data: f_q.ad};
            end
            wr_seen_q <= wr_act ? 1'b1 : (act ? wr_seen_q : 1'b0);
        end
    end
    // commit once the write strobe or select rises
    logic commit;
    assign commit = wr_seen_q && !wr_act;

    function automatic logic hit(input logic [7:0] a);
        return commit && (wcap_q.addr == a);
    endfunction

    // plain control registers
    logic [7:0] run_ctrl_q, ien_lo_q, ien_hi_q, run_en_q, auto_q, trig_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // R16 run mode cleared, transceiver inactive
            run_ctrl_q <= RST_BYTE;
            ien_lo_q <= RST_BYTE;
            ien_hi_q <= RST_BYTE;
            run_en_q <= RST_BYTE;
            auto_q <= RST_BYTE;
        end else begin
            if (hit(OFF_RUN_CTRL)) run_ctrl_q <= wcap_q.data;
            if (hit(OFF_IEN_LO)) ien_lo_q <= wcap_q.data;
            if (hit(OFF_IEN_HI)) ien_hi_q <= {4'h0, wcap_q.data[3:0]};
            if (hit(OFF_RUN_ENABLE)) run_en_q <= wcap_q.data;
            if (hit(OFF_AUTO_RELOAD)) auto_q <= wcap_q.data;
        end
    end

    // R18 restart bits act as one-cycle events
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_q <= RST_BYTE;
        end else begin
            trig_q <= hit(OFF_RELOAD_TRIG) ? wcap_q.data : RST_BYTE;
        end
    end

    // R17 interval registers, low byte at even offset
    logic [7:0] ival_q [2*NUM_TIMERS];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < 2*NUM_TIMERS; k++) ival_q[k] <= RST_BYTE;
        end else if (commit && is_interval(wcap_q.addr)) begin
            ival_q[wcap_q.addr[3:0]] <= wcap_q.data;
        end
    end

    // R20 shared prescaler for the start-up timers
    logic [PW-1:0] pre_q;
    logic pre_tick;
    assign pre_tick = sym_tick && (pre_q == PRE_LAST);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= '0;
        end else if (sym_tick) begin
            pre_q <= (pre_q == PRE_LAST) ? '0 : pre_q + 1'b1;
        end
    end

    // down counters
    logic [15:0] cnt_q [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] zero_ev;
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
        logic step;
        logic [15:0] ival;
        assign ival = {ival_q[2*i+1], ival_q[2*i]};
        // R21 symbol-rate timers step every symbol
        assign step = (i < NUM_STARTUP) ? pre_tick : sym_tick;
        // R13 time-out only on transition to zero
        // R26 disabled timer never steps
        assign zero_ev[i] = run_en_q[i] && step && !trig_q[i] && (cnt_q[i] == 16'h0001);
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                cnt_q[i] <= RST_COUNT;
            end else if (trig_q[i]) begin
                cnt_q[i] <= ival; // reload on restart
            end else if (run_en_q[i] && step) begin
                // R19 continuous reload after time-out, else hold at zero
                if (cnt_q[i] != RST_COUNT) begin
                    cnt_q[i] <= cnt_q[i] - 16'h0001;
                end else if (auto_q[i]) begin
                    cnt_q[i] <= ival;
                end
            end
        end
    end

    // cause registers; host write of zero clears, hardware set wins
    logic [7:0] tcause_q, acause_q;
    logic [7:0] twmask, awmask;
    assign twmask = hit(OFF_TIMER_CAUSE) ? wcap_q.data : 8'hff;
    assign awmask = hit(OFF_ALARM_CAUSE) ? wcap_q.data : 8'hff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tcause_q <= RST_BYTE;
            acause_q <= RST_BYTE;
        end else begin
            // R12 timer causes and alarm causes kept apart
            tcause_q <= (tcause_q & twmask) | zero_ev;
            // R14 live alarm level keeps its bit set
            acause_q <= (acause_q & awmask & 8'h0f) | {4'h0, f_q.alarm};
        end
    end

    // R10 twelve sources onto one request
    // R11 only enabled sources pull the pin
    // R15 output level fixed low, enable drives it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_n_o <= 1'b0;
            irq_n_oe <= 1'b0;
        end else begin
            irq_n_o <= 1'b0;
            irq_n_oe <= |(tcause_q & ien_lo_q) || |(acause_q & ien_hi_q);
        end
    end

    // R25 meter high byte frozen when low byte is read
    logic [7:0] meter_hold_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meter_hold_q <= RST_BYTE;
        end else if (rd_start && cur_addr == OFF_METER_LO) begin
            meter_hold_q <= meter_value[15:8];
        end
    end

    // R01 shared data window; R22 scratch pad storage
    logic [7:0] win_q [WINDOW_BYTES];
    logic [7:0] spad_q [SPAD_BYTES];
    logic [5:0] rloc_q, wloc_q;
    logic rpend_q, wpend_q;

    // R02 select writes launch the access
    // R05 access waits for the next symbol edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rloc_q <= '0;
            wloc_q <= '0;
            rpend_q <= 1'b0;
            wpend_q <= 1'b0;
        end else begin
            if (hit(OFF_SPAD_RSEL)) begin
                rloc_q <= wcap_q.data[5:0];
                rpend_q <= 1'b1;
            end else if (sym_tick) begin
                rpend_q <= 1'b0;
            end
            if (hit(OFF_SPAD_WSEL)) begin
                wloc_q <= wcap_q.data[5:0];
                wpend_q <= 1'b1;
            end else if (sym_tick) begin
                wpend_q <= 1'b0;
            end
        end
    end

    // R03 read result lands in window byte zero
    // R04 window holds its bytes until host or a read replaces them
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < WINDOW_BYTES; k++) win_q[k] <= RST_BYTE;
        end else begin
            if (commit && is_window(wcap_q.addr)) begin
                win_q[wcap_q.addr[1:0]] <= wcap_q.data;
            end else if (sym_tick && rpend_q) begin
                win_q[0] <= spad_q[rloc_q];
            end
        end
    end

    // scratch pad written from window byte zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < SPAD_BYTES; k++) spad_q[k] <= RST_BYTE;
        end else if (sym_tick && wpend_q) begin
            spad_q[wloc_q] <= win_q[0];
        end
    end

    // read mux; offsets 0x80-0xff alias the window, other unmapped offsets read zero
    logic [7:0] rdata;
    always_comb begin
        rdata = RST_BYTE;
        if (is_window(cur_addr)) begin
            rdata = win_q[cur_addr[1:0]];
        end else if (is_interval(cur_addr)) begin
            rdata = ival_q[cur_addr[3:0]];
        end else begin
            unique case (cur_addr)
                OFF_RUN_CTRL: rdata = run_ctrl_q;
                OFF_IEN_LO: rdata = ien_lo_q;
                OFF_IEN_HI: rdata = ien_hi_q;
                OFF_TIMER_CAUSE: rdata = tcause_q;
                OFF_ALARM_CAUSE: rdata = acause_q;
                OFF_SPAD_RSEL: rdata = {2'b00, rloc_q};
                OFF_SPAD_WSEL: rdata = {2'b00, wloc_q};
                OFF_METER_LO: rdata = meter_value[7:0];
                OFF_METER_HI: rdata = meter_hold_q;
                OFF_RUN_ENABLE: rdata = run_en_q;
                OFF_AUTO_RELOAD: rdata = auto_q;
                default: rdata = RST_BYTE;
            endcase
        end
    end

    // R07 drive bus only while read strobe and select are low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ad_o <= RST_BYTE;
            ad_oe <= 1'b0;
        end else begin
            ad_o <= rdata;
            ad_oe <= rd_act;
        end
    end

    // run mode output, bit 0 of run control
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_mode <= 1'b0;
        end else begin
            run_mode <= run_ctrl_q[RUN_MODE_BIT];
        end
    end

endmodule

// file: verification/host_port_sva.sv
/*
  host_port_sva: port-level checks for the host port, timer and interrupt block.
  assumes it is bound to host_port_timers_irq and sees only its ports.
*/
`timescale 1ns/10ps
module host_port_sva
    import host_port_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_DIV
) (
    // clock, reset and host pins
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic rd_ds_n,
    input wire logic wr_rw,
    input wire logic bus_style_sel,
    // device outputs
    input wire logic ad_oe,
    input wire logic irq_n_o,
    input wire logic irq_n_oe,
    input wire logic run_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [4:0] idle_q;

    // cycles since select was last low, saturating so it never wraps
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_q <= 5'h1f;
        end else if (!cs_n) begin
            idle_q <= 5'h00;
        end else if (idle_q != 5'h1f) begin
            idle_q <= idle_q + 5'h01;
        end
    end

    a_pin_pulls_only: assert property (irq_n_o == 1'b0)
        else $error("request pin driven high");
    a_read_needs_sel: assert property ($rose(ad_oe) |->
        $past(cs_n, 3) == 1'b0 && $past(rd_ds_n, 3) == 1'b0)
        else $error("data driven without select and read strobe");
    a_sel_ends_read: assert property (cs_n [*8] |-> !ad_oe)
        else $error("data still driven after select rose");
    a_strobe_ends_read: assert property (rd_ds_n [*8] |-> !ad_oe)
        else $error("data still driven after strobe rose");
    a_write_no_drive: assert property (
        (!bus_style_sel && !cs_n && !wr_rw && rd_ds_n) [*6] |-> !ad_oe)
        else $error("data driven during a write");
    a_dir_read_only: assert property (
        bus_style_sel && $rose(ad_oe) |-> $past(wr_rw, 3))
        else $error("data driven with direction line at write");
    a_run_after_write: assert property ($changed(run_mode) |-> idle_q < 5'd14)
        else $error("run mode changed with no host access");
    a_reset_clears: assert property (disable iff (1'b0)
        !arst_n |=> !run_mode && !irq_n_oe && !ad_oe)
        else $error("outputs active during reset");
endmodule

// file: verification/host_bus_model.sv
/*
  host_bus_model: host processor on the 8-bit parallel bus.
  assumes straps style and mux are steady during a cycle; acts after clk rises.
*/
`timescale 1ns/10ps
module host_bus_model (
    // clock and straps
    input wire logic clk,
    input wire logic style,
    input wire logic mux,
    // device read path
    input wire logic [7:0] ad_o,
    input wire logic ad_oe,
    // host pins
    output logic cs_n,
    output logic rd_ds_n,
    output logic wr_rw,
    output logic ale,
    output logic [7:0] addr,
    output logic [7:0] ad_i
);
    logic [7:0] drv_q = 8'h00;
    logic en_q = 1'b0;

    // a released bus shows the inverse, so stale data never passes
    assign ad_i = ad_oe ? ad_o : (en_q ? drv_q : ~drv_q);

    initial begin
        cs_n = 1'b1;
        rd_ds_n = 1'b1;
        wr_rw = 1'b1;
        ale = 1'b0;
        addr = 8'h00;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // address on shared pins or on the separate bus
    task automatic put_addr(input logic [7:0] a);
        addr = mux ? ~a : a;
        ale = mux;
        drv_q = a;
        en_q = mux;
        step(6);
        ale = 1'b0;
        step(5);
    endtask

    // direction line falls before and rises after the strobes
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        put_addr(a);
        drv_q = d;
        en_q = 1'b1;
        wr_rw = ~style;
        step(5);
        cs_n = 1'b0;
        rd_ds_n = ~style;
        wr_rw = 1'b0;
        step(8);
        cs_n = 1'b1;
        rd_ds_n = 1'b1;
        wr_rw = ~style;
        step(5);
        wr_rw = 1'b1;
        en_q = 1'b0;
        step(8);
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        int n;
        put_addr(a);
        en_q = 1'b0;
        step(5);
        cs_n = 1'b0;
        rd_ds_n = 1'b0;
        n = 0;
        while (ad_oe !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        step(2);
        d = (ad_oe === 1'b1) ? ad_i : 8'hxx;
        cs_n = 1'b1;
        rd_ds_n = 1'b1;
        step(8);
    endtask
endmodule

// file: verification/testbench.sv
/*
  testbench: self-checking top for the host port, timer and interrupt block.
  assumes host_bus_model drives the bus; the bench drives straps and line side.
*/
`timescale 1ns/10ps
module testbench;
    import host_port_pkg::*;
    localparam int PS = 4;
    localparam int SYM = 20;
    logic clk;
    logic arst_n = 1'b0;
    logic style = 1'b0;
    logic mux = 1'b0;
    logic symbol_clock;
    logic [NUM_ALARMS-1:0] alarm_level = '0;
    logic [15:0] meter_value = 16'h0000;
    logic cs_n, rd_ds_n, wr_rw, ale, ad_oe, irq_n_o, irq_n_oe, run_mode;
    logic [7:0] addr, ad_i, ad_o, rd;
    int err_total = 0;
    int checked = 0;
    // row table: address, written value, value read back
    logic [7:0] row_a [9] = '{8'h00, 8'h02, 8'h03, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h0c, 8'h40};
    logic [7:0] row_d [9] = '{8'h01, 8'ha5, 8'h0f, 8'h00, 8'h3c, 8'h34, 8'h12, 8'hff, 8'h55};
    logic [7:0] row_e [9] = '{8'h01, 8'ha5, 8'h0f, 8'h00, 8'h3c, 8'h34, 8'h12, 8'h00, 8'h00};

    host_bus_model hm (.clk(clk), .style(style), .mux(mux), .ad_o(ad_o), .ad_oe(ad_oe),
        .cs_n(cs_n), .rd_ds_n(rd_ds_n), .wr_rw(wr_rw), .ale(ale), .addr(addr), .ad_i(ad_i));

    host_port_timers_irq #(.PRESCALE(PS)) dut (.clk(clk), .arst_n(arst_n), .cs_n(cs_n),
        .rd_ds_n(rd_ds_n), .wr_rw(wr_rw), .ale(ale), .bus_style_sel(style),
        .mux_bus_sel(mux), .addr(addr), .ad_i(ad_i), .ad_o(ad_o), .ad_oe(ad_oe),
        .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .symbol_clock(symbol_clock),
        .alarm_level(alarm_level), .meter_value(meter_value), .run_mode(run_mode));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // symbol clock free runs at twenty system clocks
    initial begin
        symbol_clock = 1'b0;
        forever #250 symbol_clock = ~symbol_clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        hm.bus_read(a, rd);
        check(rd, exp);
    endtask

    task automatic sym_wait(input int n);
        repeat (n * SYM) @(posedge clk);
        #2;
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog well beyond the expected five and a half thousand cycles
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        $display("ERROR at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge clk);
        #2 arst_n = 1'b1;
        sym_wait(1);
        check({7'h00, run_mode}, 8'h00);
        for (int i = 0; i < 7; i++) begin
            rchk(row_a[i], 8'h00);
        end
        // every strap combination runs the whole row table
        for (int m = 0; m < 4; m++) begin
            style = m[0];
            mux = m[1];
            sym_wait(1);
            for (int r = 0; r < 9; r++) begin
                hm.bus_write(row_a[r], row_d[r]);
                rchk(row_a[r], row_e[r]);
            end
        end
        check({7'h00, run_mode}, 8'h01);
        // window kept over two spaced write-selects
        hm.bus_write(OFF_WINDOW_BASE, 8'h5a);
        hm.bus_write(OFF_SPAD_WSEL, 8'h3f);
        sym_wait(2);
        hm.bus_write(OFF_SPAD_WSEL, 8'h01);
        sym_wait(2);
        hm.bus_write(OFF_WINDOW_BASE, 8'h00);
        // read-select then two symbols before the window
        hm.bus_write(OFF_SPAD_RSEL, 8'h3f);
        sym_wait(2);
        rchk(OFF_WINDOW_BASE, 8'h5a);
        hm.bus_write(OFF_WINDOW_BASE, 8'h00);
        hm.bus_write(OFF_SPAD_RSEL, 8'h01);
        sym_wait(2);
        rchk(OFF_WINDOW_BASE, 8'h5a);
        // loaded but disabled timer must not expire
        hm.bus_write(8'h1c, 8'h03);
        hm.bus_write(8'h1d, 8'h00);
        hm.bus_write(OFF_IEN_LO, 8'h40);
        hm.bus_write(OFF_AUTO_RELOAD, 8'h00);
        hm.bus_write(OFF_RELOAD_TRIG, 8'h40);
        sym_wait(6);
        rchk(OFF_TIMER_CAUSE, 8'h00);
        hm.bus_write(OFF_RUN_ENABLE, 8'h40);
        sym_wait(6);
        rchk(OFF_TIMER_CAUSE, 8'h40);
        check({7'h00, irq_n_oe}, 8'h01);
        hm.bus_write(OFF_TIMER_CAUSE, 8'h00);
        sym_wait(6);
        rchk(OFF_TIMER_CAUSE, 8'h00);
        check({7'h00, irq_n_oe}, 8'h00);
        hm.bus_write(OFF_AUTO_RELOAD, 8'h40);
        sym_wait(6);
        rchk(OFF_TIMER_CAUSE, 8'h40);
        hm.bus_write(OFF_IEN_LO, 8'h00);
        check({7'h00, irq_n_oe}, 8'h00);
        // start-up timer steps once per prescaler period
        hm.bus_write(OFF_RUN_ENABLE, 8'h01);
        hm.bus_write(8'h10, 8'h03);
        hm.bus_write(8'h11, 8'h00);
        hm.bus_write(OFF_TIMER_CAUSE, 8'h00);
        hm.bus_write(OFF_RELOAD_TRIG, 8'h01);
        sym_wait(4);
        rchk(OFF_TIMER_CAUSE, 8'h00);
        sym_wait(4 * PS);
        rchk(OFF_TIMER_CAUSE, 8'h01);
        // each alarm cause holds while its level stays high
        hm.bus_write(OFF_IEN_HI, 8'h0f);
        for (int i = 0; i < NUM_ALARMS; i++) begin
            alarm_level = 4'(1 << i);
            hm.bus_write(OFF_ALARM_CAUSE, 8'h00);
            rchk(OFF_ALARM_CAUSE, 8'(1 << i));
            check({7'h00, irq_n_oe}, 8'h01);
            alarm_level = '0;
            hm.bus_write(OFF_ALARM_CAUSE, 8'h00);
            rchk(OFF_ALARM_CAUSE, 8'h00);
        end
        check({7'h00, irq_n_oe}, 8'h00);
        meter_value = 16'h1234;
        rchk(OFF_METER_LO, 8'h34);
        meter_value = 16'habcd;
        rchk(OFF_METER_HI, 8'h12);
        // second reset in mid-run
        arst_n = 1'b0;
        repeat (3) @(posedge clk);
        #2 check({7'h00, run_mode}, 8'h00);
        arst_n = 1'b1;
        sym_wait(1);
        rchk(OFF_RUN_CTRL, 8'h00);
        wrap_up();
    end
endmodule

bind host_port_timers_irq host_port_sva #(.PRESCALE(PRESCALE)) chk (.clk(clk),
    .arst_n(arst_n), .cs_n(cs_n), .rd_ds_n(rd_ds_n), .wr_rw(wr_rw),
    .bus_style_sel(bus_style_sel), .ad_oe(ad_oe), .irq_n_o(irq_n_o),
    .irq_n_oe(irq_n_oe), .run_mode(run_mode));
